/* ifp_pkg.sv */
package ifp_pkg;

    // ====
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IFP_IDX_RADIO = 8'h9b;
    localparam logic [7:0] IFP_IDX_LEVEL_LOW = 8'ha9;
    localparam logic [7:0] IFP_IDX_LEVEL_HIGH = 8'hb9;
    localparam logic [7:0] IFP_IDX_TIMERS = 8'hc0;
    localparam logic [7:0] IFP_IDX_SERIAL = 8'he8;
    localparam logic [7:0] IFP_IDX_ENABLE = 8'hf0;
    localparam logic [7:0] IFP_IDX_CTRL = 8'hf1;
    localparam logic [7:0] IFP_IDX_EVT_STATUS = 8'hf2;
    localparam logic [7:0] IFP_IDX_EVT_MASK = 8'hf3;
    localparam logic [7:0] IFP_IDX_SERVICE = 8'hf4;

    // ====
    // Sizes and reset values.
    localparam int IFP_NUM_INT = 18;
    localparam int IFP_NUM_GROUP = 6;
    localparam int IFP_NUM_LEVEL = 4;
    localparam int IFP_NUM_EVT = 3;
    localparam logic [7:0] IFP_FLAG_RESET = 8'h00;
    localparam logic [5:0] IFP_LEVEL_RESET = 6'h00;
    localparam logic [1:0] IFP_RESP_OKAY = 2'h0;
    localparam logic [1:0] IFP_RESP_SLVERR = 2'h2;

    // ====
    // Interrupt numbers of sources whose flags live here.
    localparam int IFP_INT_ST = 5;
    localparam int IFP_INT_P2 = 6;
    localparam int IFP_INT_SERIAL_ZERO_TX_SRC = 7;
    localparam int IFP_INT_DMA = 8;
    localparam int IFP_INT_T1 = 9;
    localparam int IFP_INT_T2 = 10;
    localparam int IFP_INT_T3 = 11;
    localparam int IFP_INT_T4 = 12;
    localparam int IFP_INT_P0 = 13;
    localparam int IFP_INT_UTX1 = 14;
    localparam int IFP_INT_P1 = 15;
    localparam int IFP_INT_RF = 16;
    localparam int IFP_INT_WDT = 17;

    // ====
    // Field positions.
    localparam int IFP_TIM_ST = 7;
    localparam int IFP_TIM_RSVD = 6;
    localparam int IFP_TIM_P0 = 5;
    localparam int IFP_TIM_T4 = 4;
    localparam int IFP_TIM_T3 = 3;
    localparam int IFP_TIM_T2 = 2;
    localparam int IFP_TIM_T1 = 1;
    localparam int IFP_TIM_DMA = 0;
    localparam int IFP_SER_WDT = 4;
    localparam int IFP_SER_P1 = 3;
    localparam int IFP_SER_UTX1 = 2;
    localparam int IFP_SER_SERIAL_ZERO_TX_SRC = 1;
    localparam int IFP_SER_P2 = 0;
    localparam int IFP_SER_W = 5;
    localparam int IFP_RADIO_W = 2;
    localparam int IFP_GLOBAL_EN_BIT = 7;
    localparam int IFP_EVT_ACK = 0;
    localparam int IFP_EVT_RETI = 1;
    localparam int IFP_EVT_FLAG = 2;

    // ====
    // Same-level polling order, first entry wins.
    localparam logic [4:0] IFP_POLL_ORDER [IFP_NUM_INT] = '{
        5'h00, 5'h10, 5'h08, 5'h01, 5'h09, 5'h02, 5'h0a, 5'h03, 5'h0b,
        5'h04, 5'h0c, 5'h05, 5'h0d, 5'h06, 5'h07, 5'h0e, 5'h0f, 5'h11};

    function automatic logic [2:0] ifp_group_of(input logic [4:0] num);
        case (num)
            5'h00, 5'h10, 5'h08: ifp_group_of = 3'h0;
            5'h01, 5'h09, 5'h06: ifp_group_of = 3'h1;
            5'h02, 5'h0a, 5'h07: ifp_group_of = 3'h2;
            5'h03, 5'h0b, 5'h0e: ifp_group_of = 3'h3;
            5'h04, 5'h0c, 5'h0f: ifp_group_of = 3'h4;
            default: ifp_group_of = 3'h5;
        endcase
    endfunction

endpackage

/* ifp_arbiter.sv */
`timescale 1ns/1ps
module ifp_arbiter
    import ifp_pkg::*;
(
    input wire logic [IFP_NUM_INT-1:0] pending,
    input wire logic [IFP_NUM_INT-1:0] enable,
    input wire logic global_en,
    input wire logic [IFP_NUM_GROUP-1:0] level_low,
    input wire logic [IFP_NUM_GROUP-1:0] level_high,
    input wire logic [IFP_NUM_LEVEL-1:0] in_service,
    output logic req_valid,
    output logic [4:0] req_number,
    output logic [1:0] req_level
);

    // ====
    // Resolution
    logic found;
    logic [1:0] best_level;
    logic [4:0] best_number;
    logic [4:0] num;
    logic [2:0] grp;
    logic [1:0] lvl;
    logic service_busy;
    logic [1:0] service_top;

    always_comb begin
        found = 1'b0;
        best_level = 2'h0;
        best_number = 5'h00;
        num = 5'h00;
        grp = 3'h0;
        lvl = 2'h0;
        for (int i = 0; i < IFP_NUM_INT; i++) begin
            num = IFP_POLL_ORDER[i];
            grp = ifp_group_of(num);
            lvl = {level_high[grp], level_low[grp]};
            // Strict greater keeps the earlier poll entry on ties.
            if (pending[num] && enable[num] && global_en && (!found || lvl > best_level)) begin
                found = 1'b1;
                best_level = lvl;
                best_number = num;
            end
        end
        service_busy = |in_service;
        service_top = 2'h0;
        for (int j = 0; j < IFP_NUM_LEVEL; j++) begin
            if (in_service[j]) begin
                service_top = j[1:0];
            end
        end
        req_valid = found && (!service_busy || best_level > service_top);
        req_number = best_number;
        req_level = best_level;
    end

endmodule // ifp_arbiter

/* ifp_flag_priority.sv */
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - Radio event sets both radio flag bits
// - Either radio bit alone makes request pending
// - Timer flag register layout, resets zero
// - Timer 1-4 flags cleared on vectoring
// - Serial flag register layout, upper unused
// - Six groups, four levels, reset lowest
// - Level is high bit then low bit
// - Fixed group membership of sources
// - No same or lower level preemption
// - Ties resolved by fixed polling order
// - Priority registers: bits 5:0 groups, R/W
// - Flags set regardless of enable
// - Only strictly higher level preempts service
// - Global enable off blocks all acknowledges
// - Enabled pending flag requests next cycle
module ifp_flag_priority
    import ifp_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [IFP_NUM_INT-1:IFP_INT_ST] src_event,
    input wire logic [IFP_INT_ST-1:0] ext_pending,
    input wire logic cpu_vector_ack,
    input wire logic cpu_reti,
    output logic irq_request,
    output logic [4:0] irq_number,
    output logic [1:0] irq_level,
    output logic irq
);

    // ====
    // State
    logic [IFP_RADIO_W-1:0] radio_flag_pair_reg;
    logic [7:0] cpu_flag_reg_timers;
    logic [IFP_SER_W-1:0] cpu_flag_reg_serial;
    logic [IFP_NUM_GROUP-1:0] group_level_low_reg;
    logic [IFP_NUM_GROUP-1:0] group_level_high_reg;
    logic [IFP_NUM_INT-1:0] source_enable;
    logic global_irq_enable;
    logic [IFP_NUM_LEVEL-1:0] in_service;
    logic [IFP_NUM_EVT-1:0] evt_status;
    logic [IFP_NUM_EVT-1:0] evt_mask;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_index;
    logic [31:0] w_data;
    logic [3:0] w_strb;

    // ====
    // Bus decode
    logic do_write;
    logic wr_lane0;
    logic [7:0] wbyte;
    logic next_aw_held;
    logic next_w_held;
    logic next_bvalid;
    logic next_rvalid;
    logic [7:0] ar_index;
    logic [31:0] read_data;
    logic read_hit;
    logic write_hit;

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_lane0 = do_write && w_strb[0];
    assign wbyte = w_data[7:0];
    assign ar_index = s_axi_araddr[ADDR_W-1:2];

    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_bvalid = s_axi_bvalid;
        next_rvalid = s_axi_rvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
        end else if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    always_comb begin
        case (aw_index)
            IFP_IDX_RADIO, IFP_IDX_LEVEL_LOW, IFP_IDX_LEVEL_HIGH, IFP_IDX_TIMERS, IFP_IDX_SERIAL,
            IFP_IDX_ENABLE, IFP_IDX_CTRL, IFP_IDX_EVT_STATUS, IFP_IDX_EVT_MASK, IFP_IDX_SERVICE: begin
                write_hit = 1'b1;
            end
            default: begin
                write_hit = 1'b0;
            end
        endcase
    end

    // Unused bits read as zero; reserved timer bit six reads back as written.
    always_comb begin
        read_data = 32'h0000_0000;
        read_hit = 1'b1;
        case (ar_index)
            IFP_IDX_RADIO: read_data[IFP_RADIO_W-1:0] = radio_flag_pair_reg;
            IFP_IDX_LEVEL_LOW: read_data[IFP_NUM_GROUP-1:0] = group_level_low_reg;
            IFP_IDX_LEVEL_HIGH: read_data[IFP_NUM_GROUP-1:0] = group_level_high_reg;
            IFP_IDX_TIMERS: read_data[7:0] = cpu_flag_reg_timers;
            IFP_IDX_SERIAL: read_data[IFP_SER_W-1:0] = cpu_flag_reg_serial;
            IFP_IDX_ENABLE: read_data[IFP_NUM_INT-1:0] = source_enable;
            IFP_IDX_CTRL: read_data[IFP_GLOBAL_EN_BIT] = global_irq_enable;
            IFP_IDX_EVT_STATUS: read_data[IFP_NUM_EVT-1:0] = evt_status;
            IFP_IDX_EVT_MASK: read_data[IFP_NUM_EVT-1:0] = evt_mask;
            IFP_IDX_SERVICE: read_data[11:0] = {irq_request, irq_level, irq_number, in_service};
            default: read_hit = 1'b0;
        endcase
    end

    // ====
    // AXI4-Lite channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            s_axi_bvalid <= next_bvalid;
            // One write at a time: each channel reopens once the response is taken.
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready <= !next_w_held && !next_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_index <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_bresp <= IFP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_index <= s_axi_awaddr[ADDR_W-1:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bresp <= write_hit ? IFP_RESP_OKAY : IFP_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= IFP_RESP_OKAY;
        end else begin
            s_axi_rvalid <= next_rvalid;
            s_axi_arready <= !next_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rdata <= read_data;
                s_axi_rresp <= read_hit ? IFP_RESP_OKAY : IFP_RESP_SLVERR;
            end
        end
    end

    // ====
    // Flag registers
    logic vector_taken;
    logic [7:0] tim_set;
    logic [7:0] tim_auto_clear;
    logic [IFP_SER_W-1:0] ser_set;
    logic [IFP_RADIO_W-1:0] radio_set;

    assign vector_taken = cpu_vector_ack && irq_request;

    always_comb begin
        tim_set = 8'h00;
        tim_set[IFP_TIM_ST] = src_event[IFP_INT_ST];
        tim_set[IFP_TIM_P0] = src_event[IFP_INT_P0];
        tim_set[IFP_TIM_T4] = src_event[IFP_INT_T4];
        tim_set[IFP_TIM_T3] = src_event[IFP_INT_T3];
        tim_set[IFP_TIM_T2] = src_event[IFP_INT_T2];
        tim_set[IFP_TIM_T1] = src_event[IFP_INT_T1];
        tim_set[IFP_TIM_DMA] = src_event[IFP_INT_DMA];
        tim_auto_clear = 8'h00;
        if (vector_taken) begin
            tim_auto_clear[IFP_TIM_T1] = (irq_number == 5'(IFP_INT_T1));
            tim_auto_clear[IFP_TIM_T2] = (irq_number == 5'(IFP_INT_T2));
            tim_auto_clear[IFP_TIM_T3] = (irq_number == 5'(IFP_INT_T3));
            tim_auto_clear[IFP_TIM_T4] = (irq_number == 5'(IFP_INT_T4));
        end
        ser_set = {src_event[IFP_INT_WDT], src_event[IFP_INT_P1], src_event[IFP_INT_UTX1],
            src_event[IFP_INT_SERIAL_ZERO_TX_SRC], src_event[IFP_INT_P2]};
        radio_set = {IFP_RADIO_W{src_event[IFP_INT_RF]}};
    end

    // A source event always wins over a software clear or the vectoring clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_flag_reg_timers <= IFP_FLAG_RESET;
        end else if (wr_lane0 && aw_index == IFP_IDX_TIMERS) begin
            // Bit six is stored as written; software is expected to keep it at zero.
            cpu_flag_reg_timers <= wbyte | tim_set;
        end else begin
            cpu_flag_reg_timers <= (cpu_flag_reg_timers & ~tim_auto_clear) | tim_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_flag_reg_serial <= IFP_FLAG_RESET[IFP_SER_W-1:0];
        end else if (wr_lane0 && aw_index == IFP_IDX_SERIAL) begin
            cpu_flag_reg_serial <= wbyte[IFP_SER_W-1:0] | ser_set;
        end else begin
            cpu_flag_reg_serial <= cpu_flag_reg_serial | ser_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            radio_flag_pair_reg <= IFP_FLAG_RESET[IFP_RADIO_W-1:0];
        end else if (wr_lane0 && aw_index == IFP_IDX_RADIO) begin
            radio_flag_pair_reg <= wbyte[IFP_RADIO_W-1:0] | radio_set;
        end else begin
            radio_flag_pair_reg <= radio_flag_pair_reg | radio_set;
        end
    end

    // ====
    // Priority and enable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            group_level_low_reg <= IFP_LEVEL_RESET;
            group_level_high_reg <= IFP_LEVEL_RESET;
        end else if (wr_lane0) begin
            if (aw_index == IFP_IDX_LEVEL_LOW) begin
                group_level_low_reg <= wbyte[IFP_NUM_GROUP-1:0];
            end
            if (aw_index == IFP_IDX_LEVEL_HIGH) begin
                group_level_high_reg <= wbyte[IFP_NUM_GROUP-1:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            source_enable <= '0;
            global_irq_enable <= 1'b0;
            evt_mask <= '0;
        end else if (do_write) begin
            if (aw_index == IFP_IDX_ENABLE) begin
                for (int b = 0; b < IFP_NUM_INT; b++) begin
                    if (w_strb[b / 8]) begin
                        source_enable[b] <= w_data[b];
                    end
                end
            end
            if (wr_lane0 && aw_index == IFP_IDX_CTRL) begin
                global_irq_enable <= wbyte[IFP_GLOBAL_EN_BIT];
            end
            if (wr_lane0 && aw_index == IFP_IDX_EVT_MASK) begin
                evt_mask <= wbyte[IFP_NUM_EVT-1:0];
            end
        end
    end

    // ====
    // Arbitration and service tracking
    logic [IFP_NUM_INT-1:0] pending;
    logic arb_valid;
    logic [4:0] arb_number;
    logic [1:0] arb_level;
    logic [IFP_NUM_LEVEL-1:0] service_after_reti;

    always_comb begin
        pending = '0;
        pending[IFP_INT_ST-1:0] = ext_pending;
        pending[IFP_INT_ST] = cpu_flag_reg_timers[IFP_TIM_ST];
        pending[IFP_INT_P2] = cpu_flag_reg_serial[IFP_SER_P2];
        pending[IFP_INT_SERIAL_ZERO_TX_SRC] = cpu_flag_reg_serial[IFP_SER_SERIAL_ZERO_TX_SRC];
        pending[IFP_INT_DMA] = cpu_flag_reg_timers[IFP_TIM_DMA];
        pending[IFP_INT_T1] = cpu_flag_reg_timers[IFP_TIM_T1];
        pending[IFP_INT_T2] = cpu_flag_reg_timers[IFP_TIM_T2];
        pending[IFP_INT_T3] = cpu_flag_reg_timers[IFP_TIM_T3];
        pending[IFP_INT_T4] = cpu_flag_reg_timers[IFP_TIM_T4];
        pending[IFP_INT_P0] = cpu_flag_reg_timers[IFP_TIM_P0];
        pending[IFP_INT_UTX1] = cpu_flag_reg_serial[IFP_SER_UTX1];
        pending[IFP_INT_P1] = cpu_flag_reg_serial[IFP_SER_P1];
        pending[IFP_INT_RF] = |radio_flag_pair_reg;
        pending[IFP_INT_WDT] = cpu_flag_reg_serial[IFP_SER_WDT];
    end

    ifp_arbiter u_arbiter (
        .pending(pending),
        .enable(source_enable),
        .global_en(global_irq_enable),
        .level_low(group_level_low_reg),
        .level_high(group_level_high_reg),
        .in_service(in_service),
        .req_valid(arb_valid),
        .req_number(arb_number),
        .req_level(arb_level)
    );

    // Return ends the highest level in service, as nested services unwind in order.
    always_comb begin
        service_after_reti = in_service;
        if (cpu_reti) begin
            for (int k = 0; k < IFP_NUM_LEVEL; k++) begin
                if (in_service[k] && (in_service >> (k + 1)) == '0) begin
                    service_after_reti[k] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_service <= '0;
        end else if (vector_taken) begin
            in_service <= service_after_reti | (IFP_NUM_LEVEL'(1) << irq_level);
        end else begin
            in_service <= service_after_reti;
        end
    end

    // The request drops the cycle after the acknowledge so one request is never taken twice.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_request <= 1'b0;
            irq_number <= 5'h00;
            irq_level <= 2'h0;
        end else begin
            irq_request <= arb_valid && !vector_taken;
            irq_number <= arb_number;
            irq_level <= arb_level;
        end
    end

    // ====
    // Event status and interrupt line
    logic [IFP_NUM_EVT-1:0] evt_set;
    logic [IFP_NUM_EVT-1:0] evt_clear;

    always_comb begin
        evt_set = '0;
        evt_set[IFP_EVT_ACK] = vector_taken;
        evt_set[IFP_EVT_RETI] = cpu_reti;
        evt_set[IFP_EVT_FLAG] = |src_event;
        evt_clear = (wr_lane0 && aw_index == IFP_IDX_EVT_STATUS) ? wbyte[IFP_NUM_EVT-1:0] : '0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_status <= '0;
            irq <= 1'b0;
        end else begin
            evt_status <= (evt_status & ~evt_clear) | evt_set;
            irq <= |(((evt_status & ~evt_clear) | evt_set) & evt_mask);
        end
    end

endmodule // ifp_flag_priority

/* ifp_flag_priority_monitor.sv */
`timescale 1ns/1ps
module ifp_flag_priority_monitor (
    input logic aclk,
    input logic aresetn,
    input logic s_axi_awready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic cpu_vector_ack,
    input logic cpu_reti,
    input logic irq_request,
    input logic [4:0] irq_number,
    input logic [1:0] irq_level
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ====
    // In-service levels as seen from the CPU side.
    logic [3:0] svc, top;
    always_comb top = svc[3] ? 4'h8 : svc[2] ? 4'h4 : svc[1] ? 4'h2 : {3'h0, svc[0]};
    always_ff @(posedge aclk) begin
        if (!aresetn) svc <= 4'h0;
        else svc <= (cpu_reti ? svc & ~top : svc) | ((cpu_vector_ack && irq_request) ? 4'h1 << irq_level : 4'h0);
    end
    chk_ack_drops_req: assert property (cpu_vector_ack && irq_request |=> !irq_request)
        else $error("request held after ack");
    chk_no_preempt: assert property (irq_request |-> (svc >> irq_level) == 4'h0)
        else $error("preempt not higher");
    chk_after_ack: assert property (cpu_vector_ack && irq_request |-> ##1 !irq_request
        ##1 ($past(cpu_reti) || !irq_request || irq_level > $past(irq_level, 2)))
        else $error("same level after ack");
    chk_num_range: assert property (irq_request |-> irq_number < 5'h12)
        else $error("number out of range");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bresp dropped early");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata dropped early");
    chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("ar taken in answer");
    chk_aw_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("aw taken in answer");
endmodule // ifp_flag_priority_monitor
bind ifp_flag_priority ifp_flag_priority_monitor i_ifp_flag_priority_monitor (.*);

/* ifp_cpu_model.sv */
`timescale 1ns/1ps
module ifp_cpu_model (
    input logic aclk,
    input logic aresetn,
    input logic irq_request,
    input logic [4:0] irq_number,
    input logic ack_en,
    input logic reti_go,
    output logic cpu_vector_ack,
    output logic cpu_reti,
    output logic [4:0] taken
);
    // ====
    // With ack_en low the core never acknowledges.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_vector_ack <= 1'h0;
            cpu_reti <= 1'h0;
            taken <= 5'h1f;
        end else begin
            cpu_vector_ack <= ack_en && irq_request && !cpu_vector_ack;
            cpu_reti <= reti_go;
            if (cpu_vector_ack && irq_request) taken <= irq_number;
        end
    end
endmodule // ifp_cpu_model

/* ifp_flag_priority_bench.sv */
`timescale 1ns/1ps
module ifp_flag_priority_bench
    import ifp_pkg::*;
;
    logic aclk = 1'h0, aresetn = 1'h0, ack_en = 1'h0, reti_go = 1'h0;
    logic [9:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, en;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [17:5] src_event = '0;
    logic [4:0] ext_pending = '0, irq_number, taken;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic cpu_vector_ack, cpu_reti, irq_request, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, irq_level;
    int num_errors = 0, check_count = 0;
    logic [4:0] order [18] = '{0, 16, 8, 1, 9, 2, 10, 3, 11, 4, 12, 5, 13, 6, 7, 14, 15, 17};
    always #4 aclk = ~aclk;
    ifp_flag_priority i_ifp_flag_priority (.*);
    ifp_cpu_model i_ifp_cpu_model (.*);
    // ====
    // Helpers.
    task automatic chk(input logic [31:0] s, e);
        check_count++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d, logic [1:0] r = 2'h0);
        @(posedge aclk);
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'h1;
        end while ({s_axi_bvalid, s_axi_bready} !== 2'h3);
        chk(s_axi_bresp, r);
        s_axi_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] d, logic [1:0] r = 2'h0);
        @(posedge aclk);
        s_axi_araddr <= {i, 2'h0};
        s_axi_arvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'h1;
        end while ({s_axi_rvalid, s_axi_rready} !== 2'h3);
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, r);
        s_axi_rready <= 1'h0;
    endtask
    task automatic ev(input logic [17:5] m);
        @(posedge aclk);
        src_event <= m;
        @(posedge aclk);
        src_event <= '0;
    endtask
    task automatic pulse_reti();
        @(posedge aclk);
        reti_go <= 1'h1;
        @(posedge aclk);
        reti_go <= 1'h0;
    endtask
    task automatic req(input logic [4:0] n, input logic [1:0] l);
        repeat (3) @(posedge aclk);
        chk(irq_request, 1'h1);
        chk(irq_number, n);
        chk(irq_level, l);
    endtask
    // ====
    // Scenarios.
    task automatic t_regs();
        logic [7:0] ix [5] = '{IFP_IDX_LEVEL_LOW, IFP_IDX_LEVEL_HIGH, IFP_IDX_SERIAL, IFP_IDX_RADIO, IFP_IDX_TIMERS};
        logic [31:0] wv [5] = '{32'hff, 32'hff, 32'hff, 32'hff, 32'hbf};
        logic [31:0] rv [5] = '{32'h3f, 32'h3f, 32'h1f, 32'h3, 32'hbf};
        foreach (ix[k]) begin
            rd(ix[k], 32'h0);
            wr(ix[k], wv[k]);
            rd(ix[k], rv[k]);
            wr(ix[k], 32'h0);
            rd(ix[k], 32'h0);
        end
        wr(8'h01, 32'h1, IFP_RESP_SLVERR);
        rd(8'h01, 32'h0, IFP_RESP_SLVERR);
        $display("test regs done");
    endtask
    task automatic t_event();
        ev(13'h1fff);
        rd(IFP_IDX_TIMERS, 32'hbf);
        rd(IFP_IDX_SERIAL, 32'h1f);
        rd(IFP_IDX_RADIO, 32'h3);
        chk(irq_request, 1'h0);
        wr(IFP_IDX_RADIO, 32'h0);
        wr(IFP_IDX_ENABLE, 32'h10000);
        wr(IFP_IDX_CTRL, 32'h80);
        wr(IFP_IDX_RADIO, 32'h2);
        req(5'h10, 2'h0);
        $display("test event done");
    endtask
    task automatic t_poll();
        ext_pending <= 5'h1f;
        ev(13'h1fff);
        en = 32'h3ffff;
        wr(IFP_IDX_ENABLE, en);
        foreach (order[k]) begin
            req(order[k], 2'h0);
            en = en & ~(32'h1 << order[k]);
            wr(IFP_IDX_ENABLE, en);
        end
        repeat (3) @(posedge aclk);
        chk(irq_request, 1'h0);
        $display("test poll done");
    endtask
    task automatic t_level();
        wr(IFP_IDX_ENABLE, 32'h3ffff);
        for (int g = 0; g < 6; g++) begin
            for (int lv = 1; lv < 4; lv++) begin
                wr(IFP_IDX_LEVEL_LOW, lv[0] ? 32'h1 << g : 32'h0);
                wr(IFP_IDX_LEVEL_HIGH, lv[1] ? 32'h1 << g : 32'h0);
                req(g[4:0], lv[1:0]);
            end
        end
        $display("test level done");
    endtask
    task automatic t_preempt();
        wr(IFP_IDX_LEVEL_HIGH, 32'h0);
        wr(IFP_IDX_LEVEL_LOW, 32'h2);
        req(5'h1, 2'h1);
        ack_en <= 1'h1;
        repeat (4) @(posedge aclk);
        ack_en <= 1'h0;
        chk(taken, 5'h1);
        repeat (3) @(posedge aclk);
        chk(irq_request, 1'h0);
        wr(IFP_IDX_LEVEL_LOW, 32'h6);
        wr(IFP_IDX_LEVEL_HIGH, 32'h4);
        req(5'h2, 2'h3);
        rd(IFP_IDX_SERVICE, 32'he22);
        pulse_reti();
        wr(IFP_IDX_CTRL, 32'h0);
        repeat (3) @(posedge aclk);
        chk(irq_request, 1'h0);
        $display("test preempt done");
    endtask
    task automatic t_autoclr();
        ext_pending <= 5'h0;
        wr(IFP_IDX_LEVEL_LOW, 32'h0);
        wr(IFP_IDX_LEVEL_HIGH, 32'h0);
        wr(IFP_IDX_TIMERS, 32'h0);
        wr(IFP_IDX_SERIAL, 32'h0);
        wr(IFP_IDX_RADIO, 32'h0);
        wr(IFP_IDX_EVT_STATUS, 32'h7);
        wr(IFP_IDX_CTRL, 32'h80);
        ack_en <= 1'h1;
        ev(13'h0020);
        repeat (4) @(posedge aclk);
        chk(taken, 5'ha);
        rd(IFP_IDX_TIMERS, 32'h0);
        pulse_reti();
        ev(13'h0004);
        repeat (4) @(posedge aclk);
        ack_en <= 1'h0;
        chk(taken, 5'h7);
        rd(IFP_IDX_SERIAL, 32'h2);
        rd(IFP_IDX_EVT_STATUS, 32'h7);
        chk(irq, 1'h0);
        wr(IFP_IDX_EVT_MASK, 32'h1);
        repeat (2) @(posedge aclk);
        chk(irq, 1'h1);
        wr(IFP_IDX_EVT_STATUS, 32'h7);
        repeat (2) @(posedge aclk);
        chk(irq, 1'h0);
        $display("test autoclr done");
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        t_regs();
        t_event();
        t_poll();
        t_level();
        t_preempt();
        t_autoclr();
        conclude();
    end
    initial begin
        #400000;
        num_errors++;
        conclude();
    end
endmodule // ifp_flag_priority_bench
